// File: bench/sbf_monitor.sv
`timescale 1ns/1ns
// ****
// Port checker
// ****
module sbf_monitor (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Port A
    input wire logic portAClock,
    input wire logic portASelect_n,
    input wire logic portAEnable_n,
    input wire logic portAReadWrite,
    input wire logic portAOutputEnable_n,
    input wire sbf_pkg::word_t portADataOut,
    input wire logic portADataOe,
    // Port B
    input wire logic portBClock,
    input wire logic portBEnable_n,
    input wire logic portBReadWrite,
    input wire logic portBOutputEnable_n,
    input wire sbf_pkg::word_t portBDataOut,
    input wire logic portBDataOe,
    // Bypass and flags
    input wire logic bypassRequest,
    input wire logic bypassActive_n,
    input wire logic fwdFull_n,
    input wire logic fwdEmpty_n,
    input wire logic fwdAlmostFull_n,
    input wire logic fwdAlmostEmpty_n,
    input wire logic revFull_n,
    input wire logic revEmpty_n,
    input wire logic revAlmostFull_n,
    input wire logic revAlmostEmpty_n
);
    import sbf_pkg::*;
    logic [3:0] sinceReadA;
    logic [3:0] sinceReadB;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_n);
    // Pins pass a synchroniser, so read data may move only a few clocks after a read edge
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sinceReadA <= 4'hF;
            sinceReadB <= 4'hF;
        end else begin
            sinceReadA <= ($rose(portAClock) && !portAEnable_n && !portASelect_n && portAReadWrite) ? 4'h0
                : sinceReadA + {3'h0, sinceReadA != 4'hF};
            sinceReadB <= ($rose(portBClock) && !portBEnable_n && portBReadWrite) ? 4'h0
                : sinceReadB + {3'h0, sinceReadB != 4'hF};
        end
    end
    rst_values_a: assert property ($rose(rst_n) |-> !fwdEmpty_n && !revEmpty_n && fwdFull_n && revFull_n
        && !fwdAlmostEmpty_n && !revAlmostEmpty_n && fwdAlmostFull_n && revAlmostFull_n && bypassActive_n)
        else $error("flags wrong after reset");
    fwd_full_empty_a: assert property (!fwdFull_n |-> fwdEmpty_n) else $error("fwd full and empty");
    rev_full_empty_a: assert property (!revFull_n |-> revEmpty_n) else $error("rev full and empty");
    empty_almost_a: assert property (!fwdEmpty_n || !revEmpty_n |->
        (fwdEmpty_n || !fwdAlmostEmpty_n) && (revEmpty_n || !revAlmostEmpty_n)) else $error("empty not almost");
    oe_off_a: assert property (portAOutputEnable_n [*5] |=> !portADataOe) else $error("A driven while disabled");
    oe_on_a: assert property ((!portAOutputEnable_n && !portASelect_n && portAReadWrite) [*5] |=> portADataOe)
        else $error("A not driven for read");
    sel_off_a: assert property (portASelect_n [*5] |=> !portADataOe) else $error("A driven unselected");
    oe_b_off_a: assert property (portBOutputEnable_n [*5] |=> !portBDataOe) else $error("B driven wrongly");
    read_a_out_a: assert property ($changed(portADataOut) |-> sinceReadA inside {[1:7]})
        else $error("A data moved without read");
    read_b_out_a: assert property ($changed(portBDataOut) |-> sinceReadB inside {[1:7]})
        else $error("B data moved without read");
    bypass_enter_a: assert property (bypassRequest [*6] |=> !bypassActive_n) else $error("bypass not entered");
    bypass_leave_a: assert property (!bypassRequest [*6] |=> bypassActive_n) else $error("bypass stuck");
endmodule

bind sync_bidirectional_fifo sbf_monitor mon (.*);

// File: bench/sbf_port_master.sv
`timescale 1ns/1ns
// ****
// Port bus master, far side
// ****
module sbf_port_master #(
    parameter int HALF = 4
) (
    // System clock
    input wire logic clock,
    // Port pins
    output logic pinClk = 1'b0,
    output logic select_n = 1'b1,
    output logic enable_n = 1'b1,
    output logic readWrite = 1'b1,
    output logic outputEnable_n = 1'b1,
    output sbf_pkg::resource_t resource = 3'h0,
    output sbf_pkg::word_t data = 18'h2AAAA
);
    import sbf_pkg::*;
    int phase = 0;
    // Each half spans HALF system clocks so the pin synchroniser always sees it
    always @(posedge clock) begin
        phase <= (phase == HALF - 1) ? 0 : phase + 1;
        if (phase == HALF - 1) begin
            pinClk <= #1 ~pinClk;
        end
    end
    // Controls stand from a clock after the falling edge to three clocks past the rising edge
    task automatic access(input logic s, input logic e, input logic rw, input resource_t r, input word_t d,
        input logic o);
        @(negedge pinClk);
        @(posedge clock);
        #1;
        select_n = s;
        enable_n = e;
        readWrite = rw;
        resource = r;
        outputEnable_n = o;
        // A released bus shows the inverse of its last value, never a stale copy
        data = rw ? ~data : d;
        @(posedge pinClk);
        repeat (3) @(posedge clock);
        #1;
        enable_n = 1'b1;
        data = ~data;
    endtask
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ns
module testbench;
    import sbf_pkg::*;
    localparam int DEPTH = 16;
    logic clock;
    logic rst_n;
    logic bypassRequest;
    logic aClk, aSel_n, aEn_n, aRw, aOe_n, aOe, bClk, bEn_n, bRw, bOe_n, bOe, byp_n;
    logic fFull_n, fEmpty_n, fAf_n, fAe_n, rFull_n, rEmpty_n, rAf_n, rAe_n;
    resource_t aRes;
    word_t aDrv, bDrv, aOut, bOut, lastA, lastB;
    word_t fwd[$], rev[$], qA[$], qB[$];
    int n_fail = 0;
    int num_checks = 0;
    int cap = DEPTH;
    int fAeO = 8, fAfO = 8, rAeO = 8, rAfO = 8;
    logic [31:0] seed = 32'h8414EA68;
    wire word_t busA = aOe ? aOut : aDrv;
    wire word_t busB = bOe ? bOut : bDrv;

    sync_bidirectional_fifo #(.DEPTH(DEPTH)) uut (.clock(clock), .rst_n(rst_n),
        .portAClock(aClk), .portASelect_n(aSel_n), .portAEnable_n(aEn_n), .portAReadWrite(aRw),
        .portAOutputEnable_n(aOe_n), .resourceSelect(aRes), .portADataIn(busA), .portADataOut(aOut),
        .portADataOe(aOe), .portBClock(bClk), .portBEnable_n(bEn_n), .portBReadWrite(bRw),
        .portBOutputEnable_n(bOe_n), .portBDataIn(busB), .portBDataOut(bOut), .portBDataOe(bOe),
        .bypassRequest(bypassRequest), .bypassActive_n(byp_n), .fwdFull_n(fFull_n), .fwdEmpty_n(fEmpty_n),
        .fwdAlmostFull_n(fAf_n), .fwdAlmostEmpty_n(fAe_n), .revFull_n(rFull_n), .revEmpty_n(rEmpty_n),
        .revAlmostFull_n(rAf_n), .revAlmostEmpty_n(rAe_n));
    sbf_port_master ma (.clock(clock), .pinClk(aClk), .select_n(aSel_n), .enable_n(aEn_n), .readWrite(aRw),
        .outputEnable_n(aOe_n), .resource(aRes), .data(aDrv));
    sbf_port_master mb (.clock(clock), .pinClk(bClk), .select_n(), .enable_n(bEn_n), .readWrite(bRw),
        .outputEnable_n(bOe_n), .resource(), .data(bDrv));

    function automatic word_t rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[17:0];
    endfunction
    task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
    endtask
    task automatic chkFlags();
        settle();
        check("fwdEmpty_n", fEmpty_n, fwd.size() != 0);
        check("fwdFull_n", fFull_n, fwd.size() != DEPTH);
        check("fwdAlmostEmpty_n", fAe_n, fwd.size() > fAeO);
        check("fwdAlmostFull_n", fAf_n, fwd.size() <= DEPTH - fAfO);
        check("revEmpty_n", rEmpty_n, rev.size() != 0);
        check("revFull_n", rFull_n, rev.size() != DEPTH);
        check("revAlmostEmpty_n", rAe_n, rev.size() > rAeO);
        check("revAlmostFull_n", rAf_n, rev.size() <= DEPTH - rAfO);
    endtask
    task automatic wrA(input word_t d);
        ma.access(1'b0, 1'b0, 1'b0, 3'h0, d, 1'b1);
        if (fwd.size() < cap) fwd.push_back(d);
    endtask
    task automatic wrB(input word_t d);
        mb.access(1'b0, 1'b0, 1'b0, 3'h0, d, 1'b1);
        if (rev.size() < cap) rev.push_back(d);
    endtask
    task automatic rdA();
        lastA = rev.size() ? rev.pop_front() : lastA;
        qA.push_back(lastA);
        ma.access(1'b0, 1'b0, 1'b1, 3'h0, 18'h0, 1'b0);
    endtask
    task automatic rdB();
        lastB = fwd.size() ? fwd.pop_front() : lastB;
        qB.push_back(lastB);
        mb.access(1'b0, 1'b0, 1'b1, 3'h0, 18'h0, 1'b0);
    endtask
    // Both ports run in lockstep, so the rev flags are settled when port A checks them
    task automatic fillBoth();
        fork
            for (int i = 0; i <= DEPTH; i++) begin
                wrA(rnd());
                chkFlags();
            end
            for (int i = 0; i <= DEPTH; i++) begin
                wrB(rnd());
                settle();
            end
        join
    endtask

    // ****
    // Result watchers
    // ****
    always @(posedge aClk) begin
        if (!aEn_n && !aSel_n && aRw) begin
            repeat (6) @(posedge clock);
            #1;
            check("portADataOut", aOut, qA.pop_front());
        end
    end
    always @(posedge bClk) begin
        if (!bEn_n && bRw) begin
            repeat (6) @(posedge clock);
            #1;
            check("portBDataOut", bOut, qB.pop_front());
        end
    end

    task automatic results();
        $display("checks %0d failures %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // The sequence needs about 900 clocks; the 10000-clock limit means a hang
    initial begin
        #80000;
        n_fail++;
        results();
    end

    // ****
    // Main sequence
    // ****
    initial begin
        rst_n = 1'b0;
        bypassRequest = 1'b0;
        lastA = 18'h0;
        lastB = 18'h0;
        repeat (6) @(posedge clock);
        #1;
        rst_n = 1'b1;
        chkFlags();
        check("bypassActive_n", byp_n, 1'b1);
        check("portADataOe", aOe, 1'b0);
        $display("test reset done");
        ma.access(1'b1, 1'b0, 1'b0, 3'h0, rnd(), 1'b1);
        ma.access(1'b0, 1'b1, 1'b0, 3'h0, rnd(), 1'b1);
        chkFlags();
        $display("test idle done");
        fillBoth();
        $display("test fill done");
        fork
            repeat (DEPTH + 1) rdB();
            repeat (DEPTH + 1) rdA();
        join
        chkFlags();
        check("portADataOe", aOe, 1'b1);
        check("portBDataOe", bOe, 1'b1);
        $display("test drain done");
        for (int r = 1; r <= 4; r++) begin
            ma.access(1'b0, 1'b0, 1'b0, r[2:0], 18'(r + 1), 1'b1);
        end
        {fAeO, fAfO, rAeO, rAfO} = {32'd2, 32'd3, 32'd4, 32'd5};
        fillBoth();
        $display("test offsets done");
        rst_n = 1'b0;
        repeat (2) @(posedge clock);
        #1;
        rst_n = 1'b1;
        fwd.delete();
        rev.delete();
        {fAeO, fAfO, rAeO, rAfO, lastA, lastB} = {32'd8, 32'd8, 32'd8, 32'd8, 36'h0};
        chkFlags();
        $display("test reset again done");
        bypassRequest = 1'b1;
        repeat (8) @(posedge clock);
        #1;
        check("bypassActive_n", byp_n, 1'b0);
        cap = 1;
        wrA(rnd());
        settle();
        check("fwdFull_n", fFull_n, 1'b0);
        check("fwdEmpty_n", fEmpty_n, 1'b1);
        wrA(rnd());
        rdB();
        settle();
        check("fwdFull_n", fFull_n, 1'b1);
        check("fwdEmpty_n", fEmpty_n, 1'b0);
        wrB(rnd());
        settle();
        check("revFull_n", rFull_n, 1'b0);
        check("revEmpty_n", rEmpty_n, 1'b1);
        rdA();
        settle();
        check("revEmpty_n", rEmpty_n, 1'b0);
        repeat (10) @(posedge clock);
        $display("test bypass done");
        results();
    end
endmodule

// File: core/sbf_pkg.sv
`include "sbf_regs.svh"

package sbf_pkg;

    typedef logic [`SBF_DATA_WIDTH-1:0] word_t;
    typedef logic [2:0] resource_t;

    typedef struct packed {
        logic clk;
        logic select_n;
        logic enable_n;
        logic readWrite;
        logic outputEnable_n;
        resource_t resource;
        word_t data;
    } portAPins_t;

    typedef struct packed {
        logic clk;
        logic enable_n;
        logic readWrite;
        logic outputEnable_n;
        word_t data;
    } portBPins_t;

endpackage

// File: core/sbf_regs.svh
`ifndef SBF_REGS_SVH
`define SBF_REGS_SVH


// ****************************************
// Widths and sizes
// ****************************************
`define SBF_DATA_WIDTH 18
`define SBF_DEPTH_DEFAULT 256
`define SBF_OFFSET_DEFAULT 8

// ****************************************
// Port A resource codes (write unless noted)
// ****************************************
`define SBF_RES_DATA 3'h0
`define SBF_RES_FWD_AE 3'h1
`define SBF_RES_FWD_AF 3'h2
`define SBF_RES_REV_AE 3'h3
`define SBF_RES_REV_AF 3'h4

`endif

// File: core/sync_bidirectional_fifo.sv
`timescale 1ns/1ns
`include "sbf_regs.svh"

// ****************************************
// Flip-flop FIFO with valid/ready on both sides
// ****************************************
module sbf_fifo #(
    parameter int WIDTH = `SBF_DATA_WIDTH,
    parameter int DEPTH = `SBF_DEPTH_DEFAULT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Filling side
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    // Draining side
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wrPtr;
        logic [AW-1:0] rdPtr;
        logic [CW-1:0] count;
    } fifoState_t;

    fifoState_t st;
    fifoState_t next_st;
    logic push;
    logic pop;

    // Pointers wrap by overflow, so only powers of two are served
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
        $error("sbf_fifo: DEPTH must be a power of two >= 2");
    end

    assign inReady = (st.count != CW'(DEPTH));
    assign outValid = (st.count != '0);
    assign outData = st.mem[st.rdPtr];
    assign count = st.count;
    assign push = inValid & inReady;
    assign pop = outValid & outReady;

    always_comb begin
        next_st = st;
        if (push) begin
            next_st.mem[st.wrPtr] = inData;
            next_st.wrPtr = st.wrPtr + AW'(1);
        end
        if (pop) begin
            next_st.rdPtr = st.rdPtr + AW'(1);
        end
        if (push && !pop) begin
            next_st.count = st.count + CW'(1);
        end else if (pop && !push) begin
            next_st.count = st.count - CW'(1);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule

// ****************************************
// Bidirectional synchronous buffer, device side
// ****************************************
module sync_bidirectional_fifo #(
    parameter int DEPTH = `SBF_DEPTH_DEFAULT
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Port A
    input wire logic portAClock,
    input wire logic portASelect_n,
    input wire logic portAEnable_n,
    input wire logic portAReadWrite,
    input wire logic portAOutputEnable_n,
    input wire sbf_pkg::resource_t resourceSelect,
    input wire sbf_pkg::word_t portADataIn,
    output sbf_pkg::word_t portADataOut,
    output logic portADataOe,
    // Port B
    input wire logic portBClock,
    input wire logic portBEnable_n,
    input wire logic portBReadWrite,
    input wire logic portBOutputEnable_n,
    input wire sbf_pkg::word_t portBDataIn,
    output sbf_pkg::word_t portBDataOut,
    output logic portBDataOe,
    // Bypass control
    input wire logic bypassRequest,
    output logic bypassActive_n,
    // A-to-B flags
    output logic fwdFull_n,
    output logic fwdEmpty_n,
    output logic fwdAlmostFull_n,
    output logic fwdAlmostEmpty_n,
    // B-to-A flags
    output logic revFull_n,
    output logic revEmpty_n,
    output logic revAlmostFull_n,
    output logic revAlmostEmpty_n
);
    import sbf_pkg::*;

    localparam int CW = $clog2(DEPTH+1);
    typedef logic [CW-1:0] count_t;

    // Offsets are loaded from the low data bits
    if (CW > `SBF_DATA_WIDTH || DEPTH < `SBF_OFFSET_DEFAULT) begin
        $error("sync_bidirectional_fifo: DEPTH out of range");
    end

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        portAPins_t aSync1;
        portAPins_t aSync2;
        logic aClkLast;
        portBPins_t bSync1;
        portBPins_t bSync2;
        logic bClkLast;
        logic bypassSync1;
        logic bypassSync2;
        logic bypassMode;
        word_t fwdBypassReg;
        logic fwdBypassFull;
        word_t revBypassReg;
        logic revBypassFull;
        word_t aOut;
        logic aOe;
        word_t bOut;
        logic bOe;
        count_t fwdAeOff;
        count_t fwdAfOff;
        count_t revAeOff;
        count_t revAfOff;
        logic fwdFull_n;
        logic fwdEmpty_n;
        logic fwdAlmostFull_n;
        logic fwdAlmostEmpty_n;
        logic revFull_n;
        logic revEmpty_n;
        logic revAlmostFull_n;
        logic revAlmostEmpty_n;
    } state_t;

    state_t st;
    state_t next_st;

    logic aEdge;
    logic aAccess;
    logic aWriteData;
    logic aReadData;
    logic bEdge;
    logic bWrite;
    logic bRead;
    logic fwdInValid;
    logic fwdInReady;
    logic fwdOutValid;
    logic fwdOutReady;
    word_t fwdOutData;
    count_t fwdCount;
    logic revInValid;
    logic revInReady;
    logic revOutValid;
    logic revOutReady;
    word_t revOutData;
    count_t revCount;

    // ****************************************
    // Flag decoding shared by both directions
    // ****************************************
    function automatic logic almostEmpty_n(input count_t level, input count_t offset);
        return level > offset;
    endfunction

    function automatic logic almostFull_n(input count_t level, input count_t offset);
        return level <= (count_t'(DEPTH) - offset);
    endfunction

    function automatic logic writesOffset(input logic access, input portAPins_t pins,
                                          input resource_t code);
        return access & ~pins.readWrite & (pins.resource == code);
    endfunction

    // ****************************************
    // Port decode
    // ****************************************
    // Port clocks are sampled; an edge is seen on the second stage only
    assign aEdge = st.aSync2.clk & ~st.aClkLast;
    assign aAccess = aEdge & ~st.aSync2.select_n & ~st.aSync2.enable_n;
    assign aWriteData = aAccess & ~st.aSync2.readWrite & (st.aSync2.resource == `SBF_RES_DATA);
    assign aReadData = aAccess & st.aSync2.readWrite & (st.aSync2.resource == `SBF_RES_DATA);
    assign bEdge = st.bSync2.clk & ~st.bClkLast;
    assign bWrite = bEdge & ~st.bSync2.enable_n & ~st.bSync2.readWrite;
    assign bRead = bEdge & ~st.bSync2.enable_n & st.bSync2.readWrite;

    // A full FIFO refuses the push, so a write while full is dropped
    assign fwdInValid = aWriteData & ~st.bypassMode;
    assign fwdOutReady = bRead & ~st.bypassMode;
    assign revInValid = bWrite & ~st.bypassMode;
    assign revOutReady = aReadData & ~st.bypassMode;

    // ****************************************
    // Storage, one FIFO per direction
    // ****************************************
    sbf_fifo #(.WIDTH(`SBF_DATA_WIDTH), .DEPTH(DEPTH)) fwdFifo (
        .clock(clock),
        .rst_n(rst_n),
        .inValid(fwdInValid),
        .inReady(fwdInReady),
        .inData(st.aSync2.data),
        .outValid(fwdOutValid),
        .outReady(fwdOutReady),
        .outData(fwdOutData),
        .count(fwdCount)
    );

    sbf_fifo #(.WIDTH(`SBF_DATA_WIDTH), .DEPTH(DEPTH)) revFifo (
        .clock(clock),
        .rst_n(rst_n),
        .inValid(revInValid),
        .inReady(revInReady),
        .inData(st.bSync2.data),
        .outValid(revOutValid),
        .outReady(revOutReady),
        .outData(revOutData),
        .count(revCount)
    );

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_st = st;
        // Pins pass two flops before any logic reads them
        next_st.aSync1 = '{portAClock, portASelect_n, portAEnable_n, portAReadWrite,
                           portAOutputEnable_n, resourceSelect, portADataIn};
        next_st.aSync2 = st.aSync1;
        next_st.aClkLast = st.aSync2.clk;
        next_st.bSync1 = '{portBClock, portBEnable_n, portBReadWrite, portBOutputEnable_n,
                           portBDataIn};
        next_st.bSync2 = st.bSync1;
        next_st.bClkLast = st.bSync2.clk;
        next_st.bypassSync1 = bypassRequest;
        next_st.bypassSync2 = st.bypassSync1;
        next_st.bypassMode = st.bypassSync2;

        // Bypass: a message waits in its bypass register until the far port reads it into its output register
        if (st.bypassMode) begin
            if (aWriteData && !st.fwdBypassFull) begin
                next_st.fwdBypassReg = st.aSync2.data;
                next_st.fwdBypassFull = 1'b1;
            end
            if (bRead && st.fwdBypassFull) begin
                next_st.bOut = st.fwdBypassReg;
                next_st.fwdBypassFull = 1'b0;
            end
            if (bWrite && !st.revBypassFull) begin
                next_st.revBypassReg = st.bSync2.data;
                next_st.revBypassFull = 1'b1;
            end
            if (aReadData && st.revBypassFull) begin
                next_st.aOut = st.revBypassReg;
                next_st.revBypassFull = 1'b0;
            end
        end else begin
            if (revOutReady && revOutValid) begin
                next_st.aOut = revOutData;
            end
            if (fwdOutReady && fwdOutValid) begin
                next_st.bOut = fwdOutData;
            end
        end

        // Threshold offsets, written from port A
        if (writesOffset(aAccess, st.aSync2, `SBF_RES_FWD_AE)) begin
            next_st.fwdAeOff = st.aSync2.data[CW-1:0];
        end
        if (writesOffset(aAccess, st.aSync2, `SBF_RES_FWD_AF)) begin
            next_st.fwdAfOff = st.aSync2.data[CW-1:0];
        end
        if (writesOffset(aAccess, st.aSync2, `SBF_RES_REV_AE)) begin
            next_st.revAeOff = st.aSync2.data[CW-1:0];
        end
        if (writesOffset(aAccess, st.aSync2, `SBF_RES_REV_AF)) begin
            next_st.revAfOff = st.aSync2.data[CW-1:0];
        end

        // Bus drive follows the sampled controls
        next_st.aOe = ~st.aSync2.outputEnable_n & ~st.aSync2.select_n & st.aSync2.readWrite;
        next_st.bOe = ~st.bSync2.outputEnable_n & st.bSync2.readWrite;

        // Flags; in bypass full/empty report the message registers
        next_st.fwdFull_n = st.bypassMode ? ~st.fwdBypassFull : fwdInReady;
        next_st.fwdEmpty_n = st.bypassMode ? st.fwdBypassFull : (fwdCount != '0);
        next_st.revFull_n = st.bypassMode ? ~st.revBypassFull : revInReady;
        next_st.revEmpty_n = st.bypassMode ? st.revBypassFull : (revCount != '0);
        next_st.fwdAlmostEmpty_n = almostEmpty_n(fwdCount, st.fwdAeOff);
        next_st.fwdAlmostFull_n = almostFull_n(fwdCount, st.fwdAfOff);
        next_st.revAlmostEmpty_n = almostEmpty_n(revCount, st.revAeOff);
        next_st.revAlmostFull_n = almostFull_n(revCount, st.revAfOff);
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
            st.fwdAeOff <= count_t'(`SBF_OFFSET_DEFAULT);
            st.fwdAfOff <= count_t'(`SBF_OFFSET_DEFAULT);
            st.revAeOff <= count_t'(`SBF_OFFSET_DEFAULT);
            st.revAfOff <= count_t'(`SBF_OFFSET_DEFAULT);
            st.fwdFull_n <= 1'b1;
            st.revFull_n <= 1'b1;
            st.fwdAlmostFull_n <= 1'b1;
            st.revAlmostFull_n <= 1'b1;
            // Pin clocks start high, so a pin already high at release is no edge
            st.aSync1.clk <= 1'b1;
            st.aSync2.clk <= 1'b1;
            st.aClkLast <= 1'b1;
            st.bSync1.clk <= 1'b1;
            st.bSync2.clk <= 1'b1;
            st.bClkLast <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign portADataOut = st.aOut;
    assign portADataOe = st.aOe;
    assign portBDataOut = st.bOut;
    assign portBDataOe = st.bOe;
    assign bypassActive_n = ~st.bypassMode;
    assign fwdFull_n = st.fwdFull_n;
    assign fwdEmpty_n = st.fwdEmpty_n;
    assign fwdAlmostFull_n = st.fwdAlmostFull_n;
    assign fwdAlmostEmpty_n = st.fwdAlmostEmpty_n;
    assign revFull_n = st.revFull_n;
    assign revEmpty_n = st.revEmpty_n;
    assign revAlmostFull_n = st.revAlmostFull_n;
    assign revAlmostEmpty_n = st.revAlmostEmpty_n;
endmodule
